/* verilog/acc_pkg.sv */
// Purpose: Constants shared by the converter conversion control block
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses

package acc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_OFF_CTRL = 8'h00;
  localparam logic [7:0] ACC_OFF_DATA = 8'h04;
  localparam logic [7:0] ACC_OFF_PAIR = 8'h08;
  localparam logic [7:0] ACC_OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ACC_OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ACC_OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ACC_OFF_PRIMARY = 8'h18;

  // ----------------------------------------------------------------
  // Control, primary and pair register fields
  // ----------------------------------------------------------------
  localparam int ACC_CTRL_ENABLE_BIT = 7;
  localparam int ACC_CTRL_TRACK_BIT = 6;
  localparam int ACC_CTRL_DONE_BIT = 5;
  localparam int ACC_CTRL_BUSY_BIT = 4;
  localparam int ACC_CTRL_SRC_LSB = 1;
  localparam int ACC_PRIMARY_BUSY_BIT = 4;
  localparam int ACC_PAIR_BITS = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACC_PAIR_RESET = 8'h00;
  localparam logic [7:0] ACC_DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Start source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ACC_SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] ACC_SRC_TIMER3 = 3'h1;
  localparam logic [2:0] ACC_SRC_EXTERNAL = 3'h2;
  localparam logic [2:0] ACC_SRC_TIMER2 = 3'h3;
  localparam logic [2:0] ACC_SRC_PRIMARY = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ACC_TRACK_SAR_CLOCKS = 3;
  localparam int ACC_CONV_SAR_CLOCKS = 8;
  localparam int ACC_SAR_DIV = 20;

  // ----------------------------------------------------------------
  // Sequencer states and bus response codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_TRACK,
    ACC_CONVERT
  } acc_state_type;

  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

endpackage

/* verilog/acc_conversion_control.sv */
// Purpose: Start selection, tracking sequencer, busy and done flags for an 8-bit SAR converter
// Assumes: Single clock aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: The analog converter returns its result on sar_result at the end of a conversion

// Contract
// [R1] Exactly one of five start sources is chosen by the source select field
// [R2] Software writing one to the busy bit starts a conversion in software mode
// [R3] Timer 3 or timer 2 overflow starts a conversion in its timer mode
// [R4] A rising edge on external convert start begins a conversion in external mode
// [R5] Writing one to the primary busy bit starts both converters in companion mode
// [R6] Busy bit reads one throughout a conversion, zero when it completes
// [R7] Busy falling edge sets the done flag and requests an enabled interrupt
// [R8] The 8-bit result lands in the data register at completion
// [R9] Software clears done, sets busy, polls done, then reads the result
// [R10] Low-power select zero: track continuously except during a conversion
// [R11] Low-power select one: track 3 SAR clocks after each start, then convert
// [R12] Low-power with external start: track while the pin is low, convert on rise
// [R13] Tracking stops while the chip is in standby or sleep
// [R14] Allow at least 800 ns settling after a multiplexer change before starting
// [R15] Pair bit zero gives two single-ended inputs, one gives even plus, odd minus
// [R16] Pair bit 3 governs inputs 6 and 7, down to bit 0 for inputs 0 and 1
// [R17] Pair register bits 7 to 4 read zero and ignore writes
// [R18] Converter, track-and-hold and amplifier run only while enabled
// [R19] Start requests during a conversion or its tracking period are ignored
module acc_conversion_control
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer3_overflow,
  input wire logic timer2_overflow,
  input wire logic ext_convert_start,
  input wire logic chip_standby,
  input wire logic [7:0] sar_result,
  output logic track_enable,
  output logic convert_active,
  output logic analog_power_on,
  output logic primary_converter_start,
  output logic [3:0] pair_config_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] converter_control_reg;
  logic [7:0] input_pair_config;
  logic [7:0] data_reg;
  logic conv_in_progress_bit;
  logic conv_done_flag;
  logic irq_enable;
  logic [2:0] ext_sync;
  logic ext_level;
  logic ext_level_d;
  logic ext_rise;
  logic [7:0] sar_div;
  logic sar_tick;
  logic [3:0] sar_count;
  acc_state_type state;
  logic have_aw;
  logic have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic sw_start;
  logic primary_start;
  logic start_req;
  logic start_now;
  logic finish;
  logic done_clear;
  logic [2:0] src;
  logic low_power;
  logic enabled;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  assign src = converter_control_reg[ACC_CTRL_SRC_LSB +: 3];
  assign low_power = converter_control_reg[ACC_CTRL_TRACK_BIT];
  assign enabled = converter_control_reg[ACC_CTRL_ENABLE_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (addr_is(aw_addr, ACC_OFF_CTRL) || addr_is(aw_addr, ACC_OFF_PAIR)
            || addr_is(aw_addr, ACC_OFF_IRQ_CLEAR) || addr_is(aw_addr, ACC_OFF_IRQ_ENABLE)
            || addr_is(aw_addr, ACC_OFF_PRIMARY) || addr_is(aw_addr, ACC_OFF_DATA)
            || addr_is(aw_addr, ACC_OFF_IRQ_STATUS))
          s_axi_bresp <= ACC_RESP_OKAY;
        else
          s_axi_bresp <= ACC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign sw_start = wr_fire && addr_is(aw_addr, ACC_OFF_CTRL) && w_strb[0]
                    && w_data[ACC_CTRL_BUSY_BIT];
  assign primary_start = wr_fire && addr_is(aw_addr, ACC_OFF_PRIMARY) && w_strb[0]
                         && w_data[ACC_PRIMARY_BUSY_BIT];
  assign done_clear = wr_fire && w_strb[0] && ((addr_is(aw_addr, ACC_OFF_CTRL)
                      && !w_data[ACC_CTRL_DONE_BIT])
                      || (addr_is(aw_addr, ACC_OFF_IRQ_CLEAR) && w_data[0]));

  // ----------------------------------------------------------------
  // Control, pair configuration and interrupt enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      converter_control_reg <= ACC_CTRL_RESET;
      input_pair_config <= ACC_PAIR_RESET;
      irq_enable <= 1'b0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (addr_is(aw_addr, ACC_OFF_CTRL))
        converter_control_reg <= w_data[7:0];
      if (addr_is(aw_addr, ACC_OFF_PAIR))
        input_pair_config <= {4'h0, w_data[ACC_PAIR_BITS-1:0]}; // [R17]
      if (addr_is(aw_addr, ACC_OFF_IRQ_ENABLE))
        irq_enable <= w_data[0];
    end
  end

  // ----------------------------------------------------------------
  // External start pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync <= 3'h0;
      ext_level <= 1'b0;
      ext_level_d <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_convert_start};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
      ext_level_d <= ext_level;
    end
  end

  assign ext_rise = ext_level && !ext_level_d; // [R4]

  // ----------------------------------------------------------------
  // Start source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (src) // [R1]
      ACC_SRC_SOFTWARE: start_req = sw_start; // [R2]
      ACC_SRC_TIMER3: start_req = timer3_overflow; // [R3]
      ACC_SRC_EXTERNAL: start_req = ext_rise; // [R4]
      ACC_SRC_TIMER2: start_req = timer2_overflow; // [R3]
      ACC_SRC_PRIMARY: start_req = primary_start; // [R5]
      default: start_req = 1'b0;
    endcase
  end

  assign start_now = start_req && enabled && (state == ACC_IDLE); // [R18] [R19]

  // ----------------------------------------------------------------
  // SAR clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == ACC_IDLE)
    begin
      sar_div <= 8'h00;
      sar_tick <= 1'b0;
    end
    else if (sar_div == 8'(ACC_SAR_DIV - 1))
    begin
      sar_div <= 8'h00;
      sar_tick <= 1'b1;
    end
    else
    begin
      sar_div <= sar_div + 8'h01;
      sar_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Track and convert sequencer
  // ----------------------------------------------------------------
  assign finish = (state == ACC_CONVERT) && sar_tick
                  && (sar_count == 4'(ACC_CONV_SAR_CLOCKS - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ACC_IDLE;
      sar_count <= 4'h0;
    end
    else if (!enabled)
    begin
      state <= ACC_IDLE; // [R18]
      sar_count <= 4'h0;
    end
    else
    begin
      case (state)
        ACC_IDLE:
          if (start_now)
          begin
            sar_count <= 4'h0;
            if (low_power && src != ACC_SRC_EXTERNAL)
              state <= ACC_TRACK; // [R11]
            else
              state <= ACC_CONVERT; // [R12]
          end
        ACC_TRACK:
          if (sar_tick)
          begin
            if (sar_count == 4'(ACC_TRACK_SAR_CLOCKS - 1))
            begin
              sar_count <= 4'h0;
              state <= ACC_CONVERT; // [R11]
            end
            else
              sar_count <= sar_count + 4'h1;
          end
        ACC_CONVERT:
          if (finish)
          begin
            sar_count <= 4'h0;
            state <= ACC_IDLE;
          end
          else if (sar_tick)
            sar_count <= sar_count + 4'h1;
        default:
          state <= ACC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Busy, done flag and result
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_in_progress_bit <= 1'b0;
      conv_done_flag <= 1'b0;
      data_reg <= ACC_DATA_RESET;
    end
    else
    begin
      if (start_now)
        conv_in_progress_bit <= 1'b1; // [R6]
      else if (finish || !enabled)
        conv_in_progress_bit <= 1'b0; // [R6]
      if (finish)
      begin
        conv_done_flag <= 1'b1; // [R7]
        data_reg <= sar_result; // [R8]
      end
      else if (done_clear)
        conv_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Analog side outputs and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      track_enable <= 1'b0;
      convert_active <= 1'b0;
      analog_power_on <= 1'b0;
      primary_converter_start <= 1'b0;
      pair_config_out <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      analog_power_on <= enabled; // [R18]
      convert_active <= (state == ACC_CONVERT);
      if (!enabled || chip_standby || state == ACC_CONVERT)
        track_enable <= 1'b0; // [R10] [R13]
      else if (!low_power)
        track_enable <= 1'b1; // [R10]
      else if (src == ACC_SRC_EXTERNAL)
        track_enable <= !ext_level; // [R12]
      else
        track_enable <= (state == ACC_TRACK); // [R11]
      primary_converter_start <= primary_start && (src == ACC_SRC_PRIMARY); // [R5]
      pair_config_out <= input_pair_config[3:0]; // [R15] [R16]
      irq <= (finish || (conv_done_flag && !done_clear)) && irq_enable; // [R7]
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ACC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (addr_is(s_axi_araddr, ACC_OFF_CTRL))
          s_axi_rdata[7:0] <= {converter_control_reg[7:6], conv_done_flag,
                               conv_in_progress_bit, converter_control_reg[3:0]}; // [R6]
        else if (addr_is(s_axi_araddr, ACC_OFF_DATA))
          s_axi_rdata[7:0] <= data_reg; // [R8]
        else if (addr_is(s_axi_araddr, ACC_OFF_PAIR))
          s_axi_rdata[7:0] <= input_pair_config; // [R17]
        else if (addr_is(s_axi_araddr, ACC_OFF_IRQ_STATUS))
          s_axi_rdata[0] <= conv_done_flag;
        else if (addr_is(s_axi_araddr, ACC_OFF_IRQ_ENABLE))
          s_axi_rdata[0] <= irq_enable;
        else if (addr_is(s_axi_araddr, ACC_OFF_IRQ_CLEAR) || addr_is(s_axi_araddr, ACC_OFF_PRIMARY))
          s_axi_rresp <= ACC_RESP_OKAY;
        else
          s_axi_rresp <= ACC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* dv/acc_analog_model.sv */
// Purpose: Stand-in for the analog multiplexer and sampled source
// Assumes: The result bus is only meaningful while a conversion runs
// Notes: Outside a conversion the result bus shows the inverse of the held sample
module acc_analog_model
(
  input wire logic aclk,
  input wire logic convert_active,
  input wire logic track_enable,
  input wire logic analog_power_on,
  input wire logic [7:0] level,
  output logic [7:0] sar_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held = 8'h00;

  // Sample follows the input only while the track-and-hold tracks
  always @(posedge aclk)
  begin
    if (track_enable && analog_power_on)
      held <= level;
  end

  // Stale value is never shown as valid outside a conversion
  assign sar_result = convert_active ? held : ~held;
endmodule

/* dv/acc_conversion_control_chk.sv */
// Purpose: Port-level assertions for the conversion control block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Attached to every instance of the block by the bind at the foot
module acc_conversion_control_chk
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_standby,
  input wire logic track_enable,
  input wire logic convert_active,
  input wire logic analog_power_on,
  input wire logic primary_converter_start,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");

  property p_slverr_zero;
    s_axi_rvalid && s_axi_rresp == ACC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("error read data not zero");

  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  property p_standby_hold;
    chip_standby |=> !track_enable;
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("tracking in standby");

  property p_off_idle;
    !analog_power_on && !$past(analog_power_on) && !$past(analog_power_on, 2)
      |-> !convert_active && !track_enable;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("activity while disabled");

  property p_conv_hold;
    convert_active && $past(convert_active) |-> !$past(track_enable);
  endproperty
  a_conv_hold: assert property (p_conv_hold) else $error("tracking during conversion");

  property p_primary_pulse;
    primary_converter_start |=> !primary_converter_start;
  endproperty
  a_primary_pulse: assert property (p_primary_pulse) else $error("companion start too long");

  property p_irq_cause;
    $rose(irq) |=> !convert_active || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without completion");
endmodule

bind acc_conversion_control acc_conversion_control_chk u_chk (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_standby,
  .track_enable, .convert_active, .analog_power_on, .primary_converter_start, .irq);

/* dv/acc_conversion_control_bench.sv */
// Purpose: Self-checking bench for the conversion control block
// Assumes: Bus master tasks below, analog stand-in supplies results
// Notes: Expected values come from the bench's own model variables
module acc_conversion_control_bench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer3_overflow = 1'b0;
  logic timer2_overflow = 1'b0, ext_convert_start = 1'b0, chip_standby = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic track_enable, convert_active, analog_power_on, primary_converter_start, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, pexp;
  logic [7:0] sar_result, level = 8'h00;
  logic [3:0] pair_config_out;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int error_cnt = 0, samples_checked = 0, act_cycles = 0, trk_cycles = 0, prim_cnt = 0;

  acc_conversion_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer3_overflow, .timer2_overflow, .ext_convert_start,
    .chip_standby, .sar_result, .track_enable, .convert_active, .analog_power_on,
    .primary_converter_start, .pair_config_out, .irq);
  acc_analog_model u_src (.aclk, .convert_active, .track_enable, .analog_power_on, .level,
    .sar_result);

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (convert_active)
      act_cycles <= act_cycles + 1;
    if (track_enable && !convert_active)
      trk_cycles <= trk_cycles + 1;
    if (primary_converter_start)
      prim_cnt <= prim_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      rsp = s_axi_bresp;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bvalid), 1, "write answer");
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rvalid), 1, "read answer");
  endtask

  task automatic pulse_tmr(input logic t3);
    @(posedge aclk);
    timer3_overflow <= t3;
    timer2_overflow <= !t3;
    @(posedge aclk);
    timer3_overflow <= 1'b0;
    timer2_overflow <= 1'b0;
  endtask

  task automatic fire(input logic [2:0] src, input logic lp);
    case (src)
      3'h0: axi_wr(ACC_OFF_CTRL, {24'h0, 1'b1, lp, 2'b01, src, 1'b0});
      3'h1: pulse_tmr(1'b1);
      3'h2:
      begin
        ext_convert_start <= 1'b0;
        repeat (8) @(posedge aclk);
        ext_convert_start <= 1'b1;
      end
      3'h3: pulse_tmr(1'b0);
      default: axi_wr(ACC_OFF_PRIMARY, 32'h10);
    endcase
  endtask

  task automatic convert(input logic [2:0] src, input logic lp);
    logic [7:0] v;
    logic [31:0] c;
    int n;
    v = 8'($urandom);
    c = {24'h0, 1'b1, lp, 2'b00, src, 1'b0};
    level <= v;
    axi_wr(ACC_OFF_IRQ_ENABLE, {31'h0, src[0]});
    axi_wr(ACC_OFF_CTRL, c);
    if (src != 3'h1)
      pulse_tmr(1'b1);
    if (src != 3'h3)
      pulse_tmr(1'b0);
    axi_rd(ACC_OFF_CTRL);
    chk(rd, c, "foreign start taken");
    act_cycles = 0;
    trk_cycles = 0;
    prim_cnt = 0;
    fire(src, lp);
    repeat (100) @(posedge aclk);
    fire(src, lp);
    n = 0;
    do
    begin
      axi_rd(ACC_OFF_IRQ_STATUS);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'(src[0]), "irq level");
    axi_rd(ACC_OFF_DATA);
    chk(rd, 32'(v), "result");
    axi_rd(ACC_OFF_CTRL);
    chk(rd, c | 32'h20, "ctrl after done");
    chk(32'(act_cycles inside {[160:162]}), 1, "conversion length");
    if (lp && src != 3'h2)
      chk(32'(trk_cycles inside {[59:61]}), 1, "tracking length");
    chk(32'(prim_cnt != 0), 32'(src == 3'h4), "companion start");
    chk(32'(track_enable), 32'(!lp), "idle tracking");
    axi_wr(ACC_OFF_IRQ_CLEAR, 32'h1);
    axi_rd(ACC_OFF_IRQ_STATUS);
    chk(rd, 0, "status clear");
    chk(32'(irq), 0, "irq clear");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rd = $urandom(32'h71A34E2A);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i])
    begin
      axi_rd(offs[i]);
      chk(rd, 0, "reset value");
    end
    axi_rd(8'h1C);
    chk(32'(rsp), 32'(ACC_RESP_SLVERR), "unmapped response");
    chk(rd, 0, "unmapped data");
    axi_wr(8'h1C, 32'hFF);
    chk(32'(rsp), 32'(ACC_RESP_SLVERR), "unmapped write");
    repeat (4)
    begin
      pexp = $urandom;
      axi_wr(ACC_OFF_PAIR, pexp);
      chk(32'(rsp), 32'(ACC_RESP_OKAY), "write response");
      pexp = pexp & 32'hF;
      axi_rd(ACC_OFF_PAIR);
      chk(rd, pexp, "pair register");
      chk(32'(pair_config_out), pexp, "pair output");
    end
    repeat (80) @(posedge aclk);
    axi_wr(ACC_OFF_CTRL, 32'h80);
    repeat (3) @(posedge aclk);
    chk(32'(track_enable), 1, "continuous tracking");
    chk(32'(analog_power_on), 1, "power on");
    chip_standby <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(track_enable), 0, "standby tracking");
    chip_standby <= 1'b0;
    for (int lp = 0; lp < 2; lp++)
      for (int s = 0; s < 5; s++)
        convert(3'(s), 1'(lp));
    axi_wr(ACC_OFF_CTRL, 32'h9A);
    repeat (5) @(posedge aclk);
    axi_rd(ACC_OFF_CTRL);
    chk(rd, 32'h8A, "reserved source start");
    axi_wr(ACC_OFF_CTRL, 32'h80);
    axi_wr(ACC_OFF_CTRL, 32'h90);
    repeat (20) @(posedge aclk);
    chk(32'(convert_active), 1, "abort start");
    axi_wr(ACC_OFF_CTRL, 32'h00);
    repeat (3) @(posedge aclk);
    chk(32'(convert_active), 0, "abort");
    chk(32'(analog_power_on), 0, "power off");
    tally_and_finish;
  end

  initial
  begin
    #400000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
